// ---- common/lfb_defs.svh ----
/*
 * lfb_defs.svh - encodings, field positions and sizes of the ladder flow
 * and bit control engine.
 * Assumes it is included by its bare name wherever a macro is used.
 */
`ifndef LFB_DEFS_SVH
`define LFB_DEFS_SVH

// ------------------------------------------------------------------------
// instruction word fields
// ------------------------------------------------------------------------
`define LFB_INSTR_W 16
`define LFB_OP_MSB 15
`define LFB_OP_LSB 11
`define LFB_ARG_MSB 6
`define LFB_ARG_LSB 0
`define LFB_ARG_W 7
`define LFB_BIT_COUNT 128
`define LFB_JNUM_COUNT 100
`define LFB_JNUM_SHARED 7'h00
`define LFB_JNUM_MAX 7'h63

// ------------------------------------------------------------------------
// opcode encodings
// ------------------------------------------------------------------------
`define LFB_OP_NOP 5'h00
`define LFB_OP_LD 5'h01
`define LFB_OP_LD_NOT 5'h02
`define LFB_OP_AND 5'h03
`define LFB_OP_AND_NOT 5'h04
`define LFB_OP_OR 5'h05
`define LFB_OP_OR_NOT 5'h06
`define LFB_OP_OUT 5'h07
`define LFB_OP_OUT_NOT 5'h08
`define LFB_OP_RISE 5'h09
`define LFB_OP_FALL 5'h0a
`define LFB_OP_LATCH_SET 5'h0b
`define LFB_OP_LATCH 5'h0c
`define LFB_OP_GATE 5'h0d
`define LFB_OP_GATE_CLR 5'h0e
`define LFB_OP_SKIP 5'h0f
`define LFB_OP_SKIP_END 5'h10
`define LFB_OP_END 5'h11

// ------------------------------------------------------------------------
// sequencer state codes (gray along exec -> wrap -> exec)
// ------------------------------------------------------------------------
`define LFB_ST_EXEC 2'b00
`define LFB_ST_WRAP 2'b01
`define LFB_ST_SEARCH 2'b11

`endif

// ---- common/lfb_pkg.sv ----
/*
 * lfb_pkg.sv - types shared by the ladder flow and bit control engine.
 * Assumes lfb_defs.svh is on the include path.
 */
`include "lfb_defs.svh"

package lfb_pkg;

    // --------------------------------------------------------------------
    // instruction set
    // --------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP = `LFB_OP_NOP,
        OP_LD = `LFB_OP_LD,
        OP_LD_NOT = `LFB_OP_LD_NOT,
        OP_AND = `LFB_OP_AND,
        OP_AND_NOT = `LFB_OP_AND_NOT,
        OP_OR = `LFB_OP_OR,
        OP_OR_NOT = `LFB_OP_OR_NOT,
        OP_OUT = `LFB_OP_OUT,
        OP_OUT_NOT = `LFB_OP_OUT_NOT,
        OP_RISE_PULSE = `LFB_OP_RISE,
        OP_FALL_PULSE = `LFB_OP_FALL,
        OP_LATCH_SET = `LFB_OP_LATCH_SET,
        OP_LATCH = `LFB_OP_LATCH,
        OP_SECTION_GATE = `LFB_OP_GATE,
        OP_SECTION_GATE_CLEAR = `LFB_OP_GATE_CLR,
        OP_SKIP_START = `LFB_OP_SKIP,
        OP_SKIP_END = `LFB_OP_SKIP_END,
        OP_END = `LFB_OP_END
    } lfb_op_t;

    // --------------------------------------------------------------------
    // sequencer states
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_EXEC = `LFB_ST_EXEC,
        ST_WRAP = `LFB_ST_WRAP,
        ST_SEARCH = `LFB_ST_SEARCH
    } lfb_state_t;

endpackage

// ---- src/lfb_skip_table.sv ----
/*
 * lfb_skip_table.sv - destination table for numbered skips 01..99.
 * Assumes it is written while the program is loaded, on the engine clock.
 */
`timescale 1ns/100ps
`include "lfb_defs.svh"

module lfb_skip_table #(
    parameter int AW = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [`LFB_ARG_W-1:0] wr_num,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [`LFB_ARG_W-1:0] rd_num,
    output logic [AW-1:0] rd_addr,
    output logic rd_valid
);
    import lfb_pkg::*;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [AW-1:0] dest_mem [`LFB_JNUM_COUNT]; // address of each skip end
    logic [`LFB_JNUM_COUNT-1:0] valid_reg; // number has a recorded end

    // only numbers 01..99 are recorded; 00 is found by searching instead
    function automatic logic num_ok(input logic [`LFB_ARG_W-1:0] n);
        num_ok = (n != `LFB_JNUM_SHARED) && (n <= `LFB_JNUM_MAX);
    endfunction

    // write side: a later end with the same number overwrites the older
    always_ff @(posedge clock) begin
        if (wr_en && num_ok(wr_num)) begin
            dest_mem[wr_num] <= wr_addr;
        end
    end

    // valid flags need a defined value after reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            valid_reg <= '0;
        end else if (wr_en && num_ok(wr_num)) begin
            valid_reg[wr_num] <= 1'b1;
        end
    end

    // read side is combinational so the jump lands in one cycle
    assign rd_valid = num_ok(rd_num) && valid_reg[rd_num];
    assign rd_addr = rd_valid ? dest_mem[rd_num] : '0;

endmodule

// ---- src/lfb_engine.sv ----
/*
 * lfb_engine.sv - scan engine running a ladder program one instruction
 * per clock: logic accumulation, section gating, skips, edge pulses and
 * latching bits over a 128-bit bit memory.
 * Assumes the program is loaded through the write port while run_en is
 * low, and that input pins are asynchronous to clock.
 */
// Notes on behaviour
// - gate condition governs until the gate clear
// - gate off runs section with OFF conditions
// - gate clear takes no conditions, no operand
// - nested gates each force following outputs OFF
// - skipped instructions keep their operands unchanged
// - skip with ON condition runs normally
// - skip with OFF condition goes to end
// - jump number selects kind of skip
// - numbers 01-99 pair one start, one end
// - skip end takes no conditions, no operand
// - many skips 00 may share one end
// - skip 00 resumes after next end 00
// - skip 00 searches forward, hence slower
// - rise pulse ON one scan after OFF-ON
// - fall pulse ON one scan after ON-OFF
// - edge bit cleared on next execution
// - latch set line sets, reset line clears
// - latch bit holds inside gated-off section
// - output inside gated-off section driven OFF
// - bit terminators write one writable bit
// - latch set line evaluated before the latch
// - gate and gate clear used as pair
`timescale 1ns/100ps
`include "lfb_defs.svh"

module lfb_engine #(
    parameter int PROG_AW = 8,
    parameter int IN_BITS = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic run_en,
    input wire logic [IN_BITS-1:0] in_pins,
    input wire logic prog_we,
    input wire logic [PROG_AW-1:0] prog_addr,
    input wire logic [`LFB_INSTR_W-1:0] prog_data,
    output logic [`LFB_BIT_COUNT-1:0] bit_image,
    output logic [PROG_AW-1:0] exec_pc,
    output logic scan_done,
    output logic search_busy
);
    import lfb_pkg::*;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int PROG_DEPTH = 1 << PROG_AW;
    localparam logic [PROG_AW-1:0] PC_LAST = PROG_AW'(PROG_DEPTH - 1);
    localparam logic [`LFB_ARG_W-1:0] IN_LIMIT = `LFB_ARG_W'(IN_BITS);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [`LFB_INSTR_W-1:0] prog_mem [PROG_DEPTH]; // program words
    logic [`LFB_BIT_COUNT-1:0] bit_reg; // bit memory, inputs at bottom
    logic [PROG_DEPTH-1:0] prev_reg; // last condition per edge instance
    logic [IN_BITS-1:0] in_meta_reg; // first synchroniser stage
    logic [IN_BITS-1:0] in_sync_reg; // second synchroniser stage

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    lfb_state_t state_reg; // exec, forward search or scan wrap
    logic [PROG_AW-1:0] pc_reg; // address of the current instruction
    logic acc_reg; // running execution condition of the line
    logic gate_off_reg; // some enclosing section gate is OFF
    logic set_line_reg; // stored set line of the next latch
    logic [`LFB_ARG_W-1:0] search_num_reg; // number being searched for
    logic scan_done_reg; // one-cycle end-of-scan pulse

    // ----------------------------------------------------------------
    // decode of the current instruction
    // ----------------------------------------------------------------
    logic [`LFB_INSTR_W-1:0] instr;
    lfb_op_t op;
    logic [`LFB_ARG_W-1:0] arg;
    logic bit_val; // bit addressed by the operand
    logic eff; // condition as seen by terminators
    logic wr_ok; // operand lies in a writable area
    logic exec; // an instruction is being executed
    logic [PROG_AW-1:0] tbl_addr; // recorded end of a numbered skip
    logic tbl_valid; // numbered skip has a recorded end
    logic goto_wrap; // scan ends this cycle
    logic [PROG_AW-1:0] pc_next; // where the sequencer goes next
    logic skip_taken; // skip start with OFF condition

    function automatic logic is_last(input logic [PROG_AW-1:0] a);
        is_last = (a == PC_LAST);
    endfunction

    assign instr = prog_mem[pc_reg];
    assign op = lfb_op_t'(instr[`LFB_OP_MSB:`LFB_OP_LSB]);
    assign arg = instr[`LFB_ARG_MSB:`LFB_ARG_LSB];
    assign bit_val = bit_reg[arg];
    // an OFF gate forces OUT and the edge terminators to see an OFF condition
    assign eff = acc_reg & ~gate_off_reg;
    // input image below IN_BITS is owned by the pins, never the program
    assign wr_ok = (arg >= IN_LIMIT);
    assign exec = (state_reg == ST_EXEC);
    assign skip_taken = exec && (op == OP_SKIP_START) && !acc_reg;

    // program port; one word per strobe, loaded while the scan is idle
    always_ff @(posedge clock) begin
        if (prog_we) begin
            prog_mem[prog_addr] <= prog_data;
        end
    end

    // ----------------------------------------------------------------
    // numbered skip destinations, recorded while the program loads
    // ----------------------------------------------------------------
    lfb_skip_table #(
        .AW(PROG_AW)
    ) u_table (
        .clock(clock),
        .resetn(resetn),
        .wr_en(prog_we &&
               prog_data[`LFB_OP_MSB:`LFB_OP_LSB] == `LFB_OP_SKIP_END),
        .wr_num(prog_data[`LFB_ARG_MSB:`LFB_ARG_LSB]),
        .wr_addr(prog_addr),
        .rd_num(arg),
        .rd_addr(tbl_addr),
        .rd_valid(tbl_valid)
    );

    // ----------------------------------------------------------------
    // next program address; the last word ends the scan unless a taken numbered skip there jumps back
    // ----------------------------------------------------------------
    always_comb begin
        goto_wrap = 1'b0;
        pc_next = pc_reg + 1'b1;
        case (state_reg)
            ST_EXEC: begin
                if (op == OP_END || is_last(pc_reg)) begin
                    goto_wrap = 1'b1;
                end
                // jump number picks direct transfer or shared search
                if (skip_taken && arg != `LFB_JNUM_SHARED &&
                    tbl_valid) begin
                    // land just past the matching end
                    pc_next = tbl_addr + 1'b1;
                    goto_wrap = is_last(tbl_addr);
                end
            end
            ST_SEARCH: begin
                if (op == OP_END || is_last(pc_reg)) begin
                    goto_wrap = 1'b1; // no end found: the scan is over
                end
            end
            default: begin
                pc_next = '0;
            end
        endcase
    end

    // sequencer: state and program counter
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg <= ST_WRAP;
            pc_reg <= '0;
        end else begin
            case (state_reg)
                ST_WRAP: begin
                    pc_reg <= '0;
                    if (run_en) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    pc_reg <= pc_next;
                    if (goto_wrap) begin
                        state_reg <= ST_WRAP;
                    end else if (skip_taken &&
                                 (arg == `LFB_JNUM_SHARED ||
                                  !tbl_valid)) begin
                        // shared number, or no recorded end: walk forward
                        state_reg <= ST_SEARCH;
                    end
                end
                ST_SEARCH: begin
                    pc_reg <= pc_next;
                    if (goto_wrap) begin
                        state_reg <= ST_WRAP;
                    end else if (op == OP_SKIP_END &&
                                 arg == search_num_reg) begin
                        // resume at the instruction after the end
                        state_reg <= ST_EXEC;
                    end
                end
                default: begin
                    state_reg <= ST_WRAP;
                end
            endcase
        end
    end

    // number that the forward search looks for
    always_ff @(posedge clock) begin
        if (!resetn) begin
            search_num_reg <= '0;
        end else if (skip_taken) begin
            search_num_reg <= arg;
        end
    end

    // end-of-scan pulse, one cycle wide
    always_ff @(posedge clock) begin
        if (!resetn) begin
            scan_done_reg <= 1'b0;
        end else begin
            scan_done_reg <= (state_reg != ST_WRAP) && goto_wrap;
        end
    end

    // ----------------------------------------------------------------
    // line condition accumulator
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            acc_reg <= 1'b0;
        end else if (state_reg == ST_WRAP) begin
            acc_reg <= 1'b0;
        end else if (exec) begin
            case (op)
                OP_LD: acc_reg <= bit_val;
                OP_LD_NOT: acc_reg <= ~bit_val;
                OP_AND: acc_reg <= acc_reg & bit_val;
                OP_AND_NOT: acc_reg <= acc_reg & ~bit_val;
                OP_OR: acc_reg <= acc_reg | bit_val;
                OP_OR_NOT: acc_reg <= acc_reg | ~bit_val;
                // terminators leave the condition for parallel outputs
                default: acc_reg <= acc_reg;
            endcase
        end
    end

    // section gate: one clear closes every gate opened before it
    always_ff @(posedge clock) begin
        if (!resetn) begin
            gate_off_reg <= 1'b0;
        end else if (state_reg == ST_WRAP) begin
            gate_off_reg <= 1'b0;
        end else if (exec && op == OP_SECTION_GATE && !acc_reg) begin
            gate_off_reg <= 1'b1;
        end else if (exec && op == OP_SECTION_GATE_CLEAR) begin
            // the clear looks at no condition of its own
            gate_off_reg <= 1'b0;
        end
    end

    // latch set line, stored so it is settled before the latch runs
    always_ff @(posedge clock) begin
        if (!resetn) begin
            set_line_reg <= 1'b0;
        end else if (exec && op == OP_LATCH_SET) begin
            set_line_reg <= acc_reg;
        end
    end

    // edge detectors remember their condition per program address
    always_ff @(posedge clock) begin
        if (!resetn) begin
            prev_reg <= '0;
        end else if (exec && (op == OP_RISE_PULSE ||
                              op == OP_FALL_PULSE)) begin
            prev_reg[pc_reg] <= eff;
        end
    end

    // ----------------------------------------------------------------
    // input capture; pins are async so they pass two flops first
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            in_meta_reg <= '0;
            in_sync_reg <= '0;
        end else begin
            in_meta_reg <= in_pins;
            in_sync_reg <= in_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // bit memory; only exec and wrap states write, so skipped and searched
    // code never touches it
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            bit_reg <= '0;
        end else if (state_reg == ST_WRAP) begin
            // inputs are sampled once per scan for a stable image
            if (run_en) begin
                bit_reg[IN_BITS-1:0] <= in_sync_reg;
            end
        end else if (exec && wr_ok) begin
            case (op)
                OP_OUT: bit_reg[arg] <= eff;
                OP_OUT_NOT: bit_reg[arg] <= ~acc_reg & ~gate_off_reg;
                // pulse only on a change; unchanged condition clears it
                OP_RISE_PULSE: begin
                    bit_reg[arg] <= eff & ~prev_reg[pc_reg];
                end
                OP_FALL_PULSE: begin
                    bit_reg[arg] <= ~eff & prev_reg[pc_reg];
                end
                OP_LATCH: begin
                    // a gated-off section leaves the latch untouched
                    if (!gate_off_reg) begin
                        if (acc_reg) begin
                            bit_reg[arg] <= 1'b0;
                        end else if (set_line_reg) begin
                            bit_reg[arg] <= 1'b1;
                        end
                    end
                end
                // skip end and gate clear carry no bit operand
                default: bit_reg <= bit_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bit_image = bit_reg;
    assign exec_pc = pc_reg;
    assign scan_done = scan_done_reg;
    assign search_busy = (state_reg == ST_SEARCH);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    out_gated_off_a: assert property (
        (exec && op == OP_OUT && wr_ok && gate_off_reg)
        |=> !bit_reg[$past(arg)])
        else $error("output inside gated-off section not cleared");
    latch_hold_a: assert property (
        (exec && op == OP_LATCH && gate_off_reg) |=> $stable(bit_reg))
        else $error("latch changed inside gated-off section");
    rise_pulse_a: assert property (
        (exec && op == OP_RISE_PULSE && wr_ok && eff &&
         !prev_reg[pc_reg]) |=> bit_reg[$past(arg)])
        else $error("rise pulse missing");
    edge_clear_a: assert property (
        (exec && (op == OP_RISE_PULSE || op == OP_FALL_PULSE) && wr_ok &&
         prev_reg[pc_reg] == eff) |=> !bit_reg[$past(arg)])
        else $error("edge bit not cleared without a change");
    latch_reset_a: assert property (
        (exec && op == OP_LATCH && wr_ok && !gate_off_reg && acc_reg)
        |=> !bit_reg[$past(arg)])
        else $error("latch reset did not win");
    skip_on_a: assert property (
        (exec && op == OP_SKIP_START && acc_reg && !is_last(pc_reg))
        |=> exec && pc_reg == PROG_AW'($past(pc_reg) + 1'b1))
        else $error("skip with ON condition did not fall through");
    skip_direct_a: assert property (
        (skip_taken && arg != `LFB_JNUM_SHARED && tbl_valid &&
         !is_last(tbl_addr))
        |=> exec && pc_reg == PROG_AW'($past(tbl_addr) + 1'b1))
        else $error("numbered skip missed its end");
    search_quiet_a: assert property (
        (state_reg == ST_SEARCH) |=> $stable(bit_reg))
        else $error("bit memory changed during skip");
    search_land_a: assert property (
        (state_reg == ST_SEARCH && op == OP_SKIP_END &&
         arg == search_num_reg && !is_last(pc_reg) && op != OP_END)
        |=> exec && pc_reg == PROG_AW'($past(pc_reg) + 1'b1))
        else $error("search did not resume after the end");
    gate_nest_a: assert property (
        (exec && op == OP_SECTION_GATE && !acc_reg) |=> gate_off_reg)
        else $error("gate with OFF condition not applied");
    input_area_a: assert property (
        (state_reg != ST_WRAP) |=> $stable(bit_reg[IN_BITS-1:0]))
        else $error("program wrote the input area");

    taken_numbered_c: cover property (skip_taken && tbl_valid);
    shared_search_c: cover property (
        state_reg == ST_SEARCH && op == OP_SKIP_END);
    rise_seen_c: cover property (
        exec && op == OP_RISE_PULSE && eff && !prev_reg[pc_reg]);
    latch_set_c: cover property (
        exec && op == OP_LATCH && set_line_reg && !acc_reg);

endmodule

// ---- tb/lfb_testbench.sv ----
/*
 * lfb_testbench.sv - self-checking bench for the ladder scan engine.
 * Assumes lfb_engine with PROG_AW=8, IN_BITS=16; one scan per step.
 */
`timescale 1ns/100ps
`include "lfb_defs.svh"

module testbench;
    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    logic clock = 1'b0; // 40 MHz
    logic resetn = 1'b0; // held low 16 cycles
    logic run_en = 1'b0; // one scan per step
    logic [15:0] in_pins = 16'h0000;
    logic prog_we = 1'b0;
    logic [7:0] prog_addr = 8'h00;
    logic [15:0] prog_data = 16'h0000;
    logic [127:0] bit_image;
    logic [7:0] exec_pc;
    logic scan_done;
    logic search_busy;
    int search_count = 0; // search cycles seen so far
    int search_mark = 0; // search_count at the start of a step
    int bad_count = 0;
    int total_checks = 0;
    // ld0 rise20 fall21 ld3 gate ld4 out23 ld1 lset ld2 latch22 gclr
    // ld5 skip01 ld4 out24 end01 ld6 skip00 ld4 out25 end00
    // ldn0 andn3 or5 outn26 end
    localparam logic [15:0] PROG [27] = '{
        16'h0800, 16'h4820, 16'h5021, 16'h0803, 16'h6800, 16'h0804,
        16'h3823, 16'h0801, 16'h5800, 16'h0802, 16'h6022, 16'h7000,
        16'h0805, 16'h7801, 16'h0804, 16'h3824, 16'h8001, 16'h0806,
        16'h7800, 16'h0804, 16'h3825, 16'h8000, 16'h1000, 16'h2003,
        16'h2805, 16'h4026, 16'h8800};

    always #12.5 clock = ~clock;

    lfb_engine #(.PROG_AW(8), .IN_BITS(16)) dut (
        .clock(clock), .resetn(resetn), .run_en(run_en),
        .in_pins(in_pins), .prog_we(prog_we), .prog_addr(prog_addr),
        .prog_data(prog_data), .bit_image(bit_image),
        .exec_pc(exec_pc), .scan_done(scan_done),
        .search_busy(search_busy));

    // counts search cycles; a step compares against its start mark
    always @(posedge clock) begin
        if (search_busy === 1'b1) begin
            search_count <= search_count + 1;
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one scan with given pins; compares bits 0x20..0x26 afterwards
    task automatic step(input logic [15:0] pins, input logic [6:0] exp);
        int n;
        in_pins = pins;
        search_mark = search_count;
        // pins pass a two-flop synchroniser before the scan copies them
        repeat (4) @(posedge clock) #1;
        run_en = 1'b1;
        n = 0;
        do begin
            @(posedge clock) #1;
            n++;
        end while (scan_done !== 1'b1 && n < 200);
        // dropped before the wrap edge so exactly one scan runs
        run_en = 1'b0;
        check({1'b0, bit_image[38:32]}, {1'b0, exp});
        $display("step pins=%h done", pins);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock) #1;
        resetn = 1'b1;
        for (int i = 0; i < 27; i++) begin
            prog_we = 1'b1;
            prog_addr = 8'(i);
            prog_data = PROG[i];
            @(posedge clock) #1;
        end
        prog_we = 1'b0;
        step(16'h0000, 7'h00);
        step(16'h0001, 7'h41);
        step(16'h0001, 7'h40);
        step(16'h0000, 7'h02);
        step(16'h0000, 7'h00);
        step(16'h007a, 7'h3c);
        check(8'(search_count != search_mark), 8'h00);
        step(16'h0074, 7'h34);
        step(16'h0004, 7'h34);
        check(8'(search_count != search_mark), 8'h01);
        step(16'h000e, 7'h70);
        end_of_test();
    end

    // hang guard: a few hundred cycles per step at most
    initial begin
        #(25 * 5000);
        bad_count++;
        end_of_test();
    end
endmodule
